// File: async_serial_defines.svh
// Register map, field positions and counts of the async serial channel
//
// Behaviour
// (R1) Nonzero stop field puts receiver and transmitter in asynchronous mode.
// (R2) Receiver checks one stop bit; low stop sets framing flag on character.
// (R3) Framing flag belongs to its character; host reads it before the data.
// (R4) Receive length five to eight bits, right-justified, unused bits one.
// (R5) Format bit 0 enables parity both ways; bit 1 selects even sense.
// (R6) Received parity bit stored with data when data plus parity fits eight.
// (R7) Parity error latches until error reset; special condition if enabled.
// (R8) Null character with framing error sets break until a one arrives.
// (R9) Break end leaves one null character, no framing, odd parity flagged.
// (R10) One shared clock factor of 1, 16, 32 or 64 for both directions.
// (R11) Encodings other than NRZ allowed only with the x1 clock factor.
// (R12) Terminal-ready pin outputs inverse of the DTR bit.
// (R13) With gating, receiver disabled while DCD high, enabled while low.
// (R14) With gating, transmitter disabled while CTS high, enabled while low.
// (R15) Host writes format, then controls, then enables receiver or transmitter.
// (R16) Transmitter sends one, one-and-a-half or two stop bits.
// (R17) Transmit length five to eight; five-bit formatting sends one to five.
// (R18) Transmitter appends one parity bit of selected sense when enabled.
// (R19) Send-break gives continuous zeros, starting and ending at cell edges.
// (R20) All-sent flag set only when transmitter empty and last bit left pin.
// (R21) Host avoids one-and-a-half stop bits with the x1 clock factor.
// (R22) RTS pin inverse of RTS bit; with gating held low until all sent.
`ifndef ASYNC_SERIAL_DEFINES_SVH
`define ASYNC_SERIAL_DEFINES_SVH
`define ASC_OFF_FORMAT 8'h00
`define ASC_OFF_RXCTL 8'h04
`define ASC_OFF_TXCTL 8'h08
`define ASC_OFF_INTCFG 8'h0C
`define ASC_OFF_TXDATA 8'h10
`define ASC_OFF_RXDATA 8'h14
`define ASC_OFF_LSTAT 8'h18
`define ASC_OFF_ESTAT 8'h1C
`define ASC_OFF_CMD 8'h20
`define ASC_OFF_LCODE 8'h24
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2
`define ASC_REG_RESET 8'h00
`define ASC_FIFO_DEPTH 3
`define ASC_TICKS_X1 7'h01
`define ASC_TICKS_X16 7'h10
`define ASC_TICKS_X32 7'h20
`define ASC_TICKS_X64 7'h40
`define ASC_CODE_NRZI 2'h1
`define ASC_FM_PAR_EN 0
`define ASC_FM_PAR_EVEN 1
`define ASC_FM_STOP 3:2
`define ASC_FM_FACTOR 7:6
`define ASC_RC_RX_EN 0
`define ASC_RC_AUTO 5
`define ASC_RC_LEN 7:6
`define ASC_TC_RTS 1
`define ASC_TC_TX_EN 3
`define ASC_TC_BREAK 4
`define ASC_TC_LEN 6:5
`define ASC_TC_DTR 7
`define ASC_IC_PAR_SPECIAL 2
`define ASC_CMD_ERR_RST 0
`define ASC_LS_RX_AVAIL 0
`define ASC_LS_TX_EMPTY 2
`define ASC_LS_DCD 3
`define ASC_LS_CTS 5
`define ASC_LS_BREAK 7
`define ASC_ES_ALL_SENT 0
`define ASC_ES_PARITY 4
`define ASC_ES_OVERRUN 5
`define ASC_ES_FRAME 6
`endif

// File: async_serial_pkg.sv
// Types shared by the async serial channel and its bench
package async_serial_pkg;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axiReq_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axiRsp_t;
	typedef struct packed {
		logic [7:0] data;
		logic parityErr;
		logic frameErr;
	} rxEntry_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} txState_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK} rxState_t;
endpackage : async_serial_pkg

// File: async_serial_channel.sv
// Asynchronous serial channel with AXI4-Lite register access
`timescale 1ns/1ps
`include "async_serial_defines.svh"
module async_serial_channel (
	input wire clock,
	input wire rst_n,
	input async_serial_pkg::axiReq_t axiIn,
	output async_serial_pkg::axiRsp_t axiOut,
	input wire rxd,
	input wire rxClk,
	input wire txClk,
	input wire dcdPinN,
	input wire ctsPinN,
	output logic txd,
	output logic rtsPinN,
	output logic dtrPinN,
	output logic specialRx
);
	import async_serial_pkg::*;

	// Clock factor code to ticks of the bit clock per data bit
	function automatic logic [6:0] factorTicks(input logic [1:0] code);
		case (code)
			2'h0: factorTicks = `ASC_TICKS_X1;
			2'h1: factorTicks = `ASC_TICKS_X16;
			2'h2: factorTicks = `ASC_TICKS_X32;
			default: factorTicks = `ASC_TICKS_X64;
		endcase
	endfunction : factorTicks

	// Length code to bits per character
	function automatic logic [3:0] charLen(input logic [1:0] code);
		charLen = 4'h5 + {2'h0, code};
	endfunction : charLen

	// Five-bit formatting: leading ones mark how many bits are sent
	function automatic logic [3:0] fiveBitCount(input logic [7:0] d);
		casez (d[7:3])
			5'b0????: fiveBitCount = 4'h5;
			5'b10???: fiveBitCount = 4'h4;
			5'b110??: fiveBitCount = 4'h3;
			5'b1110?: fiveBitCount = 4'h2;
			default: fiveBitCount = 4'h1;
		endcase
	endfunction : fiveBitCount

	// Mask of the positions above the first n received bits
	function automatic logic [7:0] onesAbove(input logic [3:0] n);
		logic [8:0] m;
		m = 9'h001 << n;
		onesAbove = ~(m[7:0] - 8'h01);
	endfunction : onesAbove

	// Word-aligned address inside the register window
	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a[1:0] == 2'h0) && (a <= `ASC_OFF_LCODE);
	endfunction : isMapped

	logic [7:0] fmt_q, rxCtl_q, txCtl_q, intCfg_q;
	logic [1:0] lineCode_q;
	logic awReady_q, wReady_q, awHeld_q, wHeld_q, bValid_q, arReady_q;
	logic rValid_q;
	logic [7:0] awAddr_q, wData_q;
	logic wStrb0_q;
	logic [1:0] bResp_q, rResp_q;
	logic [31:0] rData_q;
	logic [7:0] rdMux;
	rxState_t rxState_q;
	txState_t txState_q;
	logic rxClkPrev_q, txClkPrev_q, rxLinePrev_q;
	logic [6:0] rxCnt_q;
	logic [7:0] rxShift_q, txShift_q, txBuf_q, txCnt_q;
	logic [3:0] rxIdx_q, txIdx_q, txBits_q;
	logic rxPar_q, rxZero_q, rxBreak_q, rxPush_q;
	rxEntry_t rxPushEntry_q;
	rxEntry_t rxMem_q [`ASC_FIFO_DEPTH];
	logic [1:0] rxWrPtr_q, rxRdPtr_q, rxCount_q;
	logic parLatch_q, overrun_q, specialRx_q;
	logic txBufFull_q, txPar_q, txBrk_q, txPhys_q, txd_q, allSent_q;
	logic rtsPinN_q, dtrPinN_q, txBitNext;

	// Field decode and bit timing, shared and per direction
	wire asyncMode = fmt_q[`ASC_FM_STOP] != 2'h0; // [R1]
	wire parEn = fmt_q[`ASC_FM_PAR_EN]; // [R5]
	wire parEven = fmt_q[`ASC_FM_PAR_EVEN]; // [R5]
	wire [6:0] factor = factorTicks(fmt_q[`ASC_FM_FACTOR]); // [R10]
	wire nrziOn = (factor == `ASC_TICKS_X1) && (lineCode_q == `ASC_CODE_NRZI); // [R11]
	wire autoEn = rxCtl_q[`ASC_RC_AUTO];
	wire rxEnabled = asyncMode && rxCtl_q[`ASC_RC_RX_EN] && !(autoEn && dcdPinN); // [R13]
	wire txEnabled = asyncMode && txCtl_q[`ASC_TC_TX_EN] && !(autoEn && ctsPinN); // [R14]
	wire rxTick = rxClk && !rxClkPrev_q;
	wire txTick = txClk && !txClkPrev_q;
	wire [3:0] rxLen = charLen(rxCtl_q[`ASC_RC_LEN]); // [R4]
	wire [3:0] rxTotal = rxLen + {3'h0, parEn}; // [R6]
	wire [6:0] rxHalf = factor >> 1;
	wire rxSample = rxTick && (rxCnt_q == factor - 7'h01);
	// NRZI decode: a transition is a zero, no transition a one
	wire rxBit = nrziOn ? ~(rxd ^ rxLinePrev_q) : rxd; // [R11]
	wire [8:0] stopProd = {2'h0, factor} * {6'h00, fmt_q[`ASC_FM_STOP] + 3'h1};
	wire [7:0] stopTicks = stopProd[8:1]; // [R16]
	wire [7:0] txLimit = (txState_q == TX_STOP) ? stopTicks - 8'h01 : {1'b0, factor} - 8'h01;
	wire txBoundary = txTick && (txCnt_q == txLimit);
	wire txGo = txBufFull_q && txEnabled; // [R14]
	wire txIdle = (txState_q == TX_IDLE) && !txBufFull_q;

	// Bus handshake terms
	wire awTake = axiIn.awvalid && awReady_q;
	wire wTake = axiIn.wvalid && wReady_q;
	wire doWrite = awHeld_q && wHeld_q && !bValid_q;
	wire wrLow = doWrite && wStrb0_q && isMapped(awAddr_q);
	wire arTake = axiIn.arvalid && arReady_q;
	wire errRst = wrLow && (awAddr_q == `ASC_OFF_CMD) && wData_q[`ASC_CMD_ERR_RST];
	wire txWrite = wrLow && (awAddr_q == `ASC_OFF_TXDATA) && !txBufFull_q;
	wire rxPop = arTake && (axiIn.araddr == `ASC_OFF_RXDATA) && (rxCount_q != 2'h0);
	wire rxDrop = rxPush_q && (rxCount_q == 2'(`ASC_FIFO_DEPTH)) && !rxPop;
	wire rxWrite = rxPush_q && !rxDrop;
	rxEntry_t rxTop;
	assign rxTop = rxMem_q[rxRdPtr_q];

	// Write channel: address and data taken in either order, answered once both
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 8'h00;
			wStrb0_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= `ASC_RESP_OKAY;
		end
		else
		begin
			if (awTake)
			begin
				awReady_q <= 1'b0;
				awHeld_q <= 1'b1;
				awAddr_q <= axiIn.awaddr;
			end
			if (wTake)
			begin
				wReady_q <= 1'b0;
				wHeld_q <= 1'b1;
				wData_q <= axiIn.wdata[7:0];
				wStrb0_q <= axiIn.wstrb[0];
			end
			if (doWrite)
			begin
				bValid_q <= 1'b1;
				bResp_q <= isMapped(awAddr_q) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
			end
			if (bValid_q && axiIn.bready)
			begin
				bValid_q <= 1'b0;
				awReady_q <= 1'b1;
				wReady_q <= 1'b1;
			end
		end
	end

	// Control registers; only byte lane 0 carries bits
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fmt_q <= `ASC_REG_RESET;
			rxCtl_q <= `ASC_REG_RESET;
			txCtl_q <= `ASC_REG_RESET;
			intCfg_q <= `ASC_REG_RESET;
			lineCode_q <= 2'h0;
		end
		else if (wrLow)
		begin
			case (awAddr_q)
				`ASC_OFF_FORMAT: fmt_q <= wData_q;
				`ASC_OFF_RXCTL: rxCtl_q <= wData_q;
				`ASC_OFF_TXCTL: txCtl_q <= wData_q;
				`ASC_OFF_INTCFG: intCfg_q <= wData_q;
				`ASC_OFF_LCODE: lineCode_q <= wData_q[1:0];
				default: ;
			endcase
		end
	end

	// Read mux; status shows the top character's own framing flag
	always_comb
	begin
		rdMux = 8'h00;
		case (axiIn.araddr)
			`ASC_OFF_FORMAT: rdMux = fmt_q;
			`ASC_OFF_RXCTL: rdMux = rxCtl_q;
			`ASC_OFF_TXCTL: rdMux = txCtl_q;
			`ASC_OFF_INTCFG: rdMux = intCfg_q;
			`ASC_OFF_LCODE: rdMux = {6'h00, lineCode_q};
			`ASC_OFF_RXDATA: rdMux = rxTop.data;
			`ASC_OFF_LSTAT:
			begin
				rdMux[`ASC_LS_RX_AVAIL] = rxCount_q != 2'h0;
				rdMux[`ASC_LS_TX_EMPTY] = !txBufFull_q;
				rdMux[`ASC_LS_DCD] = !dcdPinN;
				rdMux[`ASC_LS_CTS] = !ctsPinN; // [R14]
				rdMux[`ASC_LS_BREAK] = rxBreak_q; // [R8]
			end
			`ASC_OFF_ESTAT:
			begin
				rdMux[`ASC_ES_ALL_SENT] = allSent_q; // [R20]
				rdMux[`ASC_ES_PARITY] = parLatch_q;
				rdMux[`ASC_ES_OVERRUN] = overrun_q;
				rdMux[`ASC_ES_FRAME] = (rxCount_q != 2'h0) && rxTop.frameErr; // [R3]
			end
			default: rdMux = 8'h00;
		endcase
	end

	// Read channel: one read at a time, answered the cycle after the address
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arReady_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= `ASC_RESP_OKAY;
		end
		else if (arTake)
		begin
			arReady_q <= 1'b0;
			rValid_q <= 1'b1;
			rData_q <= {24'h000000, rdMux};
			rResp_q <= isMapped(axiIn.araddr) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
		end
		else if (rValid_q && axiIn.rready)
		begin
			rValid_q <= 1'b0;
			arReady_q <= 1'b1;
		end
	end

	// Receiver: mid-bit sampling, one stop bit checked, break tracking
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxClkPrev_q <= 1'b0;
			rxLinePrev_q <= 1'b1;
			rxState_q <= RX_IDLE;
			rxCnt_q <= 7'h00;
			rxShift_q <= 8'hFF;
			rxIdx_q <= 4'h0;
			rxPar_q <= 1'b0;
			rxZero_q <= 1'b1;
			rxBreak_q <= 1'b0;
			rxPush_q <= 1'b0;
			rxPushEntry_q <= '0;
		end
		else
		begin
			rxClkPrev_q <= rxClk;
			rxPush_q <= 1'b0;
			if (rxTick)
				rxLinePrev_q <= rxd;
			if (rxState_q != RX_IDLE && !rxEnabled)
			begin
				// Dropping the enable abandons the character in progress
				rxState_q <= RX_IDLE;
				rxBreak_q <= 1'b0;
			end
			else if (rxTick)
			begin
				case (rxState_q)
					RX_IDLE:
						if (rxEnabled && !rxBit)
						begin
							rxState_q <= (rxHalf == 7'h00) ? RX_DATA : RX_START;
							rxCnt_q <= 7'h00;
							rxShift_q <= 8'hFF; // [R4]
							rxIdx_q <= 4'h0;
							rxPar_q <= 1'b0;
							rxZero_q <= 1'b1;
						end
					RX_START:
						if (rxCnt_q == rxHalf - 7'h01)
						begin
							// A start bit gone by mid-cell was a glitch
							rxState_q <= rxBit ? RX_IDLE : RX_DATA;
							rxCnt_q <= 7'h00;
						end
						else
							rxCnt_q <= rxCnt_q + 7'h01;
					RX_DATA:
						if (!rxSample)
							rxCnt_q <= rxCnt_q + 7'h01;
						else
						begin
							rxCnt_q <= 7'h00;
							if (rxIdx_q < 4'h8)
								rxShift_q[rxIdx_q[2:0]] <= rxBit; // [R4] [R6]
							rxPar_q <= rxPar_q ^ rxBit;
							if (rxIdx_q < rxLen)
								rxZero_q <= rxZero_q & !rxBit;
							rxIdx_q <= rxIdx_q + 4'h1;
							if (rxIdx_q + 4'h1 == rxTotal)
								rxState_q <= RX_STOP;
						end
					RX_STOP:
						if (!rxSample)
							rxCnt_q <= rxCnt_q + 7'h01;
						else
						begin
							rxCnt_q <= 7'h00;
							rxState_q <= (rxZero_q && !rxBit) ? RX_BREAK : RX_IDLE;
							rxBreak_q <= rxZero_q && !rxBit; // [R8]
							rxPush_q <= !(rxZero_q && !rxBit);
							rxPushEntry_q.data <= rxShift_q;
							rxPushEntry_q.parityErr <= parEn && (rxPar_q == parEven); // [R5]
							rxPushEntry_q.frameErr <= !rxBit; // [R2]
						end
					RX_BREAK:
						if (rxBit)
						begin
							// Break over: leave a single null behind
							rxState_q <= RX_IDLE;
							rxBreak_q <= 1'b0; // [R8]
							rxPush_q <= 1'b1;
							rxPushEntry_q.data <= onesAbove(rxTotal); // [R9]
							rxPushEntry_q.parityErr <= parEn && !parEven; // [R9]
							rxPushEntry_q.frameErr <= 1'b0; // [R9]
						end
					default: rxState_q <= RX_IDLE;
				endcase
			end
		end
	end

	// Receive FIFO entries, each with its own error flags
	for (genvar i = 0; i < `ASC_FIFO_DEPTH; i++)
	begin : g_rxMem
		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
				rxMem_q[i] <= '0;
			else if (rxWrite && rxWrPtr_q == 2'(i))
				rxMem_q[i] <= rxPushEntry_q; // [R2]
		end
	end

	// FIFO pointers; a full FIFO drops the new character and flags overrun
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxWrPtr_q <= 2'h0;
			rxRdPtr_q <= 2'h0;
			rxCount_q <= 2'h0;
		end
		else
		begin
			if (rxWrite)
				rxWrPtr_q <= (rxWrPtr_q == 2'(`ASC_FIFO_DEPTH - 1)) ? 2'h0 : rxWrPtr_q + 2'h1;
			if (rxPop)
				rxRdPtr_q <= (rxRdPtr_q == 2'(`ASC_FIFO_DEPTH - 1)) ? 2'h0 : rxRdPtr_q + 2'h1;
			rxCount_q <= rxCount_q + {1'b0, rxWrite} - {1'b0, rxPop};
		end
	end

	// Sticky errors: a new error in the reset cycle still sets the flag
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			parLatch_q <= 1'b0;
			overrun_q <= 1'b0;
			specialRx_q <= 1'b0;
		end
		else
		begin
			parLatch_q <= (rxWrite && rxPushEntry_q.parityErr) || (parLatch_q && !errRst); // [R7]
			overrun_q <= rxDrop || (overrun_q && !errRst);
			specialRx_q <= (rxCount_q != 2'h0) && (rxTop.frameErr ||
				(parLatch_q && intCfg_q[`ASC_IC_PAR_SPECIAL])); // [R2] [R7]
		end
	end

	// Next logical level to put on the line at a cell boundary
	always_comb
	begin
		txBitNext = 1'b1;
		case (txState_q)
			TX_IDLE: txBitNext = !txGo;
			TX_START: txBitNext = txShift_q[0];
			TX_DATA:
				if (txIdx_q < txBits_q)
					txBitNext = txShift_q[0];
				else if (parEn)
					txBitNext = txPar_q ^ !parEven; // [R18]
				else
					txBitNext = 1'b1;
			TX_PARITY: txBitNext = 1'b1;
			TX_STOP: txBitNext = !txGo;
			default: txBitNext = 1'b1;
		endcase
	end

	// Transmitter: every change lands on a bit-cell boundary
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txClkPrev_q <= 1'b0;
			txState_q <= TX_IDLE;
			txCnt_q <= 8'h00;
			txShift_q <= 8'h00;
			txIdx_q <= 4'h0;
			txBits_q <= 4'h8;
			txPar_q <= 1'b0;
			txBrk_q <= 1'b0;
			txPhys_q <= 1'b1;
		end
		else
		begin
			txClkPrev_q <= txClk;
			if (txTick)
				txCnt_q <= txBoundary ? 8'h00 : txCnt_q + 8'h01;
			if (txBoundary)
			begin
				txBrk_q <= txCtl_q[`ASC_TC_BREAK]; // [R19]
				// NRZI: a zero toggles the line, a one holds it
				txPhys_q <= nrziOn ? (txBitNext ? txPhys_q : !txPhys_q) : txBitNext;
				case (txState_q)
					TX_IDLE, TX_STOP:
						if (txGo)
						begin
							txState_q <= TX_START;
							txShift_q <= txBuf_q;
							txIdx_q <= 4'h0;
							txPar_q <= 1'b0;
							txBits_q <= (charLen(txCtl_q[`ASC_TC_LEN]) == 4'h5) ?
								fiveBitCount(txBuf_q) : charLen(txCtl_q[`ASC_TC_LEN]); // [R17]
						end
						else
							txState_q <= TX_IDLE;
					TX_START, TX_DATA:
						if (txState_q == TX_START || txIdx_q < txBits_q)
						begin
							txState_q <= TX_DATA;
							txShift_q <= {1'b0, txShift_q[7:1]};
							txPar_q <= txPar_q ^ txShift_q[0];
							txIdx_q <= txIdx_q + 4'h1;
						end
						else
							txState_q <= parEn ? TX_PARITY : TX_STOP; // [R18]
					TX_PARITY: txState_q <= TX_STOP; // [R16]
					default: txState_q <= TX_IDLE;
				endcase
			end
		end
	end

	// Holding buffer; a write while full is ignored
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txBufFull_q <= 1'b0;
			txBuf_q <= 8'h00;
		end
		else if (txWrite)
		begin
			txBufFull_q <= 1'b1;
			txBuf_q <= wData_q;
		end
		else if (txBoundary && txGo && (txState_q == TX_IDLE || txState_q == TX_STOP))
			txBufFull_q <= 1'b0;
	end

	// Pins and drained flag, all registered
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txd_q <= 1'b1;
			allSent_q <= 1'b1;
			rtsPinN_q <= 1'b1;
			dtrPinN_q <= 1'b1;
		end
		else
		begin
			txd_q <= txBrk_q ? 1'b0 : txPhys_q; // [R19]
			// A write into an idle buffer clears the flag in the same edge
			allSent_q <= txIdle && !txWrite && txd_q == txPhys_q; // [R20]
			rtsPinN_q <= !(txCtl_q[`ASC_TC_RTS] || (autoEn && !rtsPinN_q && !allSent_q)); // [R22]
			dtrPinN_q <= !txCtl_q[`ASC_TC_DTR]; // [R12]
		end
	end

	assign txd = txd_q;
	assign rtsPinN = rtsPinN_q;
	assign dtrPinN = dtrPinN_q;
	assign specialRx = specialRx_q;
	assign axiOut = '{awready: awReady_q, wready: wReady_q, bvalid: bValid_q,
		bresp: bResp_q, arready: arReady_q, rvalid: rValid_q, rdata: rData_q,
		rresp: rResp_q};

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence breakEnds;
		rxState_q == RX_BREAK && rxEnabled && rxTick && rxBit;
	endsequence

	a_sync_idle: assert property ((!asyncMode && txState_q == TX_IDLE) |=> txState_q == TX_IDLE) // [R1]
		else $error("transmitter left idle outside async mode");
	a_frame_flag: assert property ((rxState_q == RX_STOP && rxSample && rxEnabled && !rxZero_q)
		|=> rxPush_q && rxPushEntry_q.frameErr == !$past(rxBit)) // [R2]
		else $error("framing flag does not follow stop bit");
	a_ones_above: assert property ((rxState_q == RX_STOP && rxSample && rxEnabled)
		|-> (rxShift_q & onesAbove(rxTotal)) == onesAbove(rxTotal)) // [R4]
		else $error("unused receive bits not one");
	a_parity_latch: assert property ((parLatch_q && !errRst) |=> parLatch_q) // [R7]
		else $error("parity error lost before error reset");
	a_break_hold: assert property ((rxBreak_q && rxEnabled && !(rxTick && rxBit)) |=> rxBreak_q) // [R8]
		else $error("break flag dropped while line low");
	a_break_null: assert property (breakEnds |=> rxPush_q && !rxPushEntry_q.frameErr
		&& rxPushEntry_q.parityErr == (parEn && !parEven) && !rxBreak_q) // [R9]
		else $error("break end did not leave a clean null");
	a_dtr_pin: assert property (##1 dtrPinN_q == !$past(txCtl_q[`ASC_TC_DTR])) // [R12]
		else $error("terminal-ready pin not inverse of bit");
	a_dcd_gate: assert property ((autoEn && dcdPinN) |=> rxState_q == RX_IDLE) // [R13]
		else $error("receiver ran with carrier absent");
	a_cts_gate: assert property ((autoEn && ctsPinN && txState_q == TX_IDLE) |=> txState_q == TX_IDLE) // [R14]
		else $error("transmitter started with clear-to-send absent");
	a_break_out: assert property (txBrk_q |=> !txd_q) // [R19]
		else $error("line not low during break");
	a_all_sent: assert property (allSent_q |-> txState_q == TX_IDLE && !txBufFull_q) // [R20]
		else $error("all-sent while transmitter busy");
	a_rts_hold: assert property ((autoEn && !rtsPinN_q && !allSent_q) |=> !rtsPinN_q) // [R22]
		else $error("request-to-send released before all sent");
endmodule : async_serial_channel

// File: serial_line_model.sv
// Remote serial line: free-running x1 bit clock, frame sender, capturer
`timescale 1ns/1ps
module serial_line_model (
	output logic bitClk,
	output logic line,
	input wire txd
);
	// Async bit clocks run free, so this one never stops between frames
	initial
	begin
		bitClk = 1'b0;
		line = 1'b1;
		forever #100 bitClk = ~bitClk;
	end
	// Cells change on falling edges so the receiver samples mid-cell
	task automatic sendBits(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge bitClk);
			line = bits[i];
		end
		@(negedge bitClk);
		line = 1'b1; // Idle is marking
	endtask : sendBits
	// Wait for a start cell, then collect n cells counted from it
	task automatic capture(input int n, output logic [15:0] got);
		int w;
		w = 0;
		got = '0;
		do
		begin
			@(negedge bitClk);
			w++;
		end while (txd !== 1'b0 && w < 400);
		for (int i = 0; i < n; i++)
		begin
			got[i] = txd;
			@(negedge bitClk);
		end
	endtask : capture
endmodule : serial_line_model

// File: async_serial_channel_tb.sv
// Self-checking bench of the async serial channel on a remote line
`timescale 1ns/1ps
`include "async_serial_defines.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module async_serial_channel_tb;
	import async_serial_pkg::*;
	logic clock, rst_n, dcdPinN, ctsPinN, bitClk, line;
	logic txd, rtsPinN, dtrPinN, specialRx;
	axiReq_t axiIn;
	axiRsp_t axiOut;
	int fails, totalChecks;
	logic [31:0] d;
	logic [1:0] r;
	logic [15:0] got;
	async_serial_channel dut (.clock(clock), .rst_n(rst_n), .axiIn(axiIn),
		.axiOut(axiOut), .rxd(line), .rxClk(bitClk), .txClk(bitClk),
		.dcdPinN(dcdPinN), .ctsPinN(ctsPinN), .txd(txd), .rtsPinN(rtsPinN),
		.dtrPinN(dtrPinN), .specialRx(specialRx));
	serial_line_model far (.bitClk(bitClk), .line(line), .txd(txd));
	// 40 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		axiIn.awvalid <= 1'b1;
		axiIn.awaddr <= a;
		axiIn.wvalid <= 1'b1;
		axiIn.wdata <= {24'h000000, v};
		axiIn.wstrb <= 4'hF;
		axiIn.bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (axiOut.awready === 1'b1) axiIn.awvalid <= 1'b0;
			if (axiOut.wready === 1'b1) axiIn.wvalid <= 1'b0;
		end while (axiOut.bvalid !== 1'b1);
		axiIn.bready <= 1'b0;
	endtask : wr
	// Read: data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		axiIn.arvalid <= 1'b1;
		axiIn.araddr <= a;
		axiIn.rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (axiOut.arready === 1'b1) axiIn.arvalid <= 1'b0;
		end while (axiOut.rvalid !== 1'b1);
		d = axiOut.rdata;
		r = axiOut.rresp;
		axiIn.rready <= 1'b0;
	endtask : rd
	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, e);
		rd(a);
		`CHK(d & m, e)
	endtask : rdChk
	// Mode first, options next with the transmit enable, receiver enable last
	task automatic cfg(input logic [7:0] fm, rc, tc);
		wr(`ASC_OFF_FORMAT, fm);
		wr(`ASC_OFF_RXCTL, rc & 8'hFE);
		wr(`ASC_OFF_TXCTL, tc);
		wr(`ASC_OFF_RXCTL, rc);
	endtask : cfg
	// Expected frame: start, n data bits, optional parity, one stop
	task automatic txCase(input logic [7:0] fm, tc, v, input int n);
		logic [15:0] e;
		int p;
		p = fm[0];
		e = '0;
		for (int i = 0; i < n; i++) e[i + 1] = v[i];
		if (p == 1) e[n + 1] = (^(v & ((8'h01 << n) - 8'h01))) ^ ~fm[1];
		e[n + 1 + p] = 1'b1;
		cfg(fm, 8'h01, tc);
		fork
			far.capture(n + p + 2, got);
			begin
				wr(`ASC_OFF_TXDATA, v);
				rdChk(`ASC_OFF_ESTAT, 32'h1, 32'h0);
			end
		join
		`CHK(got & ((16'h1 << (n + p + 2)) - 16'h1), e)
		repeat (40) @(posedge clock);
		rdChk(`ASC_OFF_ESTAT, 32'h1, 32'h1);
	endtask : txCase
	// Frame bits go LSB first; error status is read before the data
	task automatic rxCase(input logic [7:0] fm, rc, input logic [31:0] b,
		input int n, input logic [7:0] v, input logic fe, sp);
		cfg(fm, rc, 8'h00);
		far.sendBits(b, n);
		repeat (20) @(posedge clock);
		`CHK(specialRx, sp)
		rdChk(`ASC_OFF_ESTAT, 32'h40, {fe, 6'h00});
		rdChk(`ASC_OFF_RXDATA, 32'hFF, v);
	endtask : rxCase
	task automatic tReset;
		`CHK({txd, rtsPinN, dtrPinN, specialRx}, 4'hE)
		rdChk(`ASC_OFF_FORMAT, 32'hFF, 32'h0);
		rd(8'h28);
		`CHK(r, `ASC_RESP_SLVERR)
		wr(`ASC_OFF_TXCTL, 8'h82);
		repeat (2) @(posedge clock);
		`CHK({rtsPinN, dtrPinN}, 2'b00)
		$display("reset and pins done");
	endtask : tReset
	task automatic tTx;
		txCase(8'h04, 8'h68, 8'h55, 8);
		txCase(8'h07, 8'h48, 8'h07, 7);
		txCase(8'h05, 8'h08, 8'hF1, 1);
		// x1 runs only ever pick one stop bit, never one-and-a-half
		wr(`ASC_OFF_TXCTL, 8'h18);
		repeat (20) @(posedge clock);
		`CHK(txd, 1'b0)
		wr(`ASC_OFF_TXCTL, 8'h08);
		repeat (20) @(posedge clock);
		`CHK(txd, 1'b1)
		$display("transmit done");
	endtask : tTx
	task automatic tRx;
		rxCase(8'h04, 8'hC1, 32'h34A, 10, 8'hA5, 1'b0, 1'b0);
		rxCase(8'h04, 8'h01, 32'h16, 7, 8'hEB, 1'b1, 1'b1);
		rxCase(8'h05, 8'h41, 32'h102, 9, 8'h81, 1'b0, 1'b0);
		wr(`ASC_OFF_INTCFG, 8'h04);
		rxCase(8'h07, 8'h81, 32'h202, 10, 8'h01, 1'b0, 1'b1);
		rdChk(`ASC_OFF_ESTAT, 32'h10, 32'h10);
		wr(`ASC_OFF_CMD, 8'h01);
		rdChk(`ASC_OFF_ESTAT, 32'h10, 32'h0);
		$display("receive done");
	endtask : tRx
	task automatic tBreak;
		cfg(8'h04, 8'hC1, 8'h00);
		fork
			far.sendBits(32'hFF000000, 32);
			begin
				repeat (150) @(posedge clock);
				rdChk(`ASC_OFF_LSTAT, 32'h80, 32'h80);
			end
		join
		repeat (20) @(posedge clock);
		rdChk(`ASC_OFF_LSTAT, 32'h80, 32'h0);
		rdChk(`ASC_OFF_ESTAT, 32'h40, 32'h0);
		rdChk(`ASC_OFF_RXDATA, 32'hFF, 32'h0);
		rdChk(`ASC_OFF_LSTAT, 32'h1, 32'h0);
		$display("break done");
	endtask : tBreak
	task automatic tGate;
		dcdPinN <= 1'b1;
		ctsPinN <= 1'b1;
		cfg(8'h04, 8'hE1, 8'h6A);
		far.sendBits(32'h34A, 10);
		rdChk(`ASC_OFF_LSTAT, 32'h1, 32'h0);
		wr(`ASC_OFF_TXDATA, 8'h55);
		repeat (100) begin @(posedge clock); `CHK(txd, 1'b1) end
		ctsPinN <= 1'b0;
		fork
			far.capture(10, got);
			begin
				repeat (60) @(posedge clock);
				wr(`ASC_OFF_TXCTL, 8'h68);
				`CHK(rtsPinN, 1'b0)
			end
		join
		`CHK(got[9:0], 10'h2AA)
		repeat (40) @(posedge clock);
		`CHK(rtsPinN, 1'b1)
		$display("gating done");
	endtask : tGate
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : reportAndStop
	// Main sequence after a two-cycle reset
	initial
	begin
		axiIn = '0;
		dcdPinN = 1'b0;
		ctsPinN = 1'b0;
		rst_n = 1'b0;
		fails = 0;
		totalChecks = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		tReset;
		tTx;
		tRx;
		tBreak;
		tGate;
		reportAndStop;
	end
	// Watchdog well beyond the expected run of a few thousand cycles
	initial
	begin
		#500000;
		fails++;
		reportAndStop;
	end
endmodule : async_serial_channel_tb
